// ### tsw_pkg.sv
// constants and carrier types of the timeslot switch memory control core
// assumes one 100 MHz clock and a host on an AXI4-Lite slave port
// Notes on behaviour
// R1 - command c8 copies the addressed control line data field into the data register
// R2 - command f0 returns the addressed control line code in data register bits 3..0
// R3 - commands 70..77 write pointer and code; 70 unassigned, 71..77 pick bit groups
// R4 - command 79 marks a microprocessor channel, data register becomes the idle byte
// R5 - 128 channels switched each way, any slot to any slot, without blocking
// R6 - 128 slots split as four ports of 32, two of 64 or one of 128
// R7 - bidirectional mode gives eight ports of 16, each slot input or output
// R8 - slots numbered 0 to N-1, each eight contiguous bits
// R9 - bit 7 travels first on serial lines and maps to data bit 7 on the bus
// R10 - even/odd slot pairs see the same frame delay
// R11 - one control line per interface slot; data field points into data memory
// R12 - host declares a slot switched by writing a code with leading zero
// R13 - one downstream source slot may feed many outputs, never upstream the reverse
// R14 - several upstream slots on one target overwrite; only distinct bit groups merge
// R15 - fresh line: host loads pointer, address, then command 71
// R16 - coded line: host loads pointer, address, then command 48 for data field only
// R17 - 2-bit and 4-bit sub-slots, single and double slots are switched
// R18 - after a read command host polls the busy flag before reading data
// R19 - code 0000 leaves the downstream interface output inactive
// R20 - host loads data and address before the command write that launches it
package tsw_pkg;
   // register byte offsets
   localparam logic [4:0] OFS_DATA   = 5'h00;
   localparam logic [4:0] OFS_ADDR   = 5'h04;
   localparam logic [4:0] OFS_CMD    = 5'h08;
   localparam logic [4:0] OFS_STATUS = 5'h0c;
   localparam logic [4:0] OFS_MODE   = 5'h10;
   // status and address fields
   localparam int BUSY_BIT = 0;
   localparam int BANK_BIT = 1;
   localparam int DIR_BIT  = 7;
   // command values
   localparam logic [7:0] CMD_RD_DATA = 8'hc8;
   localparam logic [7:0] CMD_RD_CODE = 8'hf0;
   localparam logic [7:0] CMD_WR_DATA = 8'h48;
   localparam logic [7:0] CMD_WR_UP   = 8'h79;
   localparam logic [3:0] CMD_SW_HI   = 4'h7;
   // control line codes
   localparam logic [3:0] CODE_NONE = 4'h0;
   localparam logic [3:0] CODE_B70  = 4'h1;
   localparam logic [3:0] CODE_B74  = 4'h3;
   localparam logic [3:0] CODE_B30  = 4'h2;
   localparam logic [3:0] CODE_B76  = 4'h7;
   localparam logic [3:0] CODE_B54  = 4'h6;
   localparam logic [3:0] CODE_B32  = 4'h5;
   localparam logic [3:0] CODE_B10  = 4'h4;
   localparam logic [3:0] CODE_UP   = 4'h9;
   // interface port layouts held in the mode register, last bit of a slot and bus responses
   localparam logic [1:0] MODE_4X32 = 2'h0;
   localparam logic [1:0] MODE_2X64 = 2'h1;
   localparam logic [1:0] MODE_1X128 = 2'h2;
   localparam logic [1:0] MODE_8X16 = 2'h3;
   localparam logic [2:0] LAST_BIT  = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // one control memory line
   typedef struct packed {
      logic [3:0] code;
      logic [7:0] ptr;
   } tsw_cm_line_t;
   typedef enum logic {TSW_IDLE, TSW_EXEC} tsw_state_t;
endpackage

// ### tsw_core.sv
// timeslot switch core: control memory programming over AXI4-Lite plus the
// serial switching engine between interface highway and PCM highway.
// assumes one clock; the serial lines run one bit per clock, slot 0 bit 7
// first, with frame start marked on o_frame_start.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
module tsw_core #(
   parameter int NUM_SLOTS = 128
) (
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rstn,
   // axi4-lite write channels
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [4:0]  i_awaddr,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   output logic [1:0]       o_bresp,
   // axi4-lite read channels
   input  wire logic        i_arvalid,
   output logic             o_arready,
   input  wire logic [4:0]  i_araddr,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   // pcm highway
   input  wire logic        i_pcm_rx,
   output logic             o_pcm_tx,
   // configurable interface highway, output enable high while driving
   input  wire logic        i_cfi_rx,
   output logic             o_cfi_tx,
   output logic             o_cfi_tx_oe,
   // frame marker
   output logic             o_frame_start
);
   import tsw_pkg::*;

   if (NUM_SLOTS != 128) begin : g_chk
      $error("tsw_core serves exactly 128 slots");
   end

   // control memory: lines 0..127 downstream, 128..255 upstream
   tsw_cm_line_t cm_reg [2*NUM_SLOTS];
   // data memory, two banks per direction so every slot sees one frame delay except source slot 127 into slot 0, read as it is written and two frames older
   logic [7:0]   dm_down [2][NUM_SLOTS];
   logic [7:0]   dm_up   [2][NUM_SLOTS];

   // bit sub-timeslot mask of a switching code
   function automatic logic [7:0] code_mask(input logic [3:0] c);
      logic [7:0] m;
      m = 8'h00;
      unique case (c)
         CODE_B70: m = 8'hff; // R17
         CODE_B74: m = 8'hf0;
         CODE_B30: m = 8'h0f;
         CODE_B76: m = 8'hc0;
         CODE_B54: m = 8'h30;
         CODE_B32: m = 8'h0c;
         CODE_B10: m = 8'h03;
         default:  m = 8'h00;
      endcase
      return m;
   endfunction

   // host port/slot address to a linear highway slot, ports interleaved
   function automatic logic [6:0] slot_of(input logic [1:0] md, input logic [6:0] a);
      logic [6:0] s;
      s = a;
      unique case (md)
         MODE_4X32:  s = {a[4:0], a[6:5]}; // R6
         MODE_2X64:  s = {a[5:0], a[6]};
         MODE_1X128: s = a;
         MODE_8X16:  s = {a[3:0], a[6:4]}; // R7
      endcase
      return s;
   endfunction

   // ---------------- register bus ----------------
   logic        bvalid_reg, bvalid_next;
   logic [1:0]  bresp_reg, bresp_next;
   logic        rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0]  rresp_reg, rresp_next;
   logic [7:0]  data_reg, data_next;
   logic [7:0]  addr_reg, addr_next;
   logic [7:0]  cmd_reg, cmd_next;
   logic [1:0]  mode_reg, mode_next;
   tsw_state_t  state_reg, state_next;
   logic        bank_reg, bank_next; // frame bank, also read back in status
   logic        wr_go, rd_go, lane0;
   logic [7:0]  cm_idx;
   logic        cm_we;
   tsw_cm_line_t cm_wline;

   // a write needs both channels at once; no skid buffer is kept
   always_comb begin
      wr_go = i_awvalid & i_wvalid & ~bvalid_reg;
      rd_go = i_arvalid & ~rvalid_reg;
      lane0 = wr_go & i_wstrb[0];
      o_awready = wr_go;
      o_wready  = wr_go;
      o_arready = rd_go;
   end

   // write response, unmapped offsets answer slverr
   always_comb begin
      bvalid_next = bvalid_reg & ~i_bready;
      bresp_next  = bresp_reg;
      if (wr_go) begin
         bvalid_next = 1'b1;
         bresp_next  = (i_awaddr <= OFS_MODE && i_awaddr[1:0] == 2'h0) ? RESP_OKAY
                                                                        : RESP_SLVERR;
      end
   end

   // read data mux, data bits map straight to bus bits 7..0
   always_comb begin
      rvalid_next = rvalid_reg & ~i_rready;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      if (rd_go) begin
         rvalid_next = 1'b1;
         rresp_next  = RESP_OKAY;
         rdata_next  = 32'h0000_0000;
         unique case (i_araddr)
            OFS_DATA:   rdata_next[7:0] = data_reg; // R9
            OFS_ADDR:   rdata_next[7:0] = addr_reg;
            OFS_CMD:    rdata_next[7:0] = cmd_reg;
            OFS_STATUS: begin
               rdata_next[BUSY_BIT] = (state_reg == TSW_EXEC);
               rdata_next[BANK_BIT] = bank_reg;
            end
            OFS_MODE:   rdata_next[1:0] = mode_reg;
            default:    rresp_next = RESP_SLVERR;
         endcase
      end
   end

   // command engine: a command write launches one execution cycle
   always_comb begin
      cm_idx     = {addr_reg[DIR_BIT], slot_of(mode_reg, addr_reg[6:0])}; // R11
      cm_we      = 1'b0;
      cm_wline   = cm_reg[cm_idx];
      data_next  = data_reg;
      addr_next  = addr_reg;
      cmd_next   = cmd_reg;
      mode_next  = mode_reg;
      state_next = TSW_IDLE;
      if (lane0) begin
         unique case (i_awaddr)
            OFS_DATA: data_next = i_wdata[7:0];
            OFS_ADDR: addr_next = i_wdata[7:0];
            OFS_CMD: begin
               cmd_next   = i_wdata[7:0];
               state_next = TSW_EXEC; // R20
            end
            OFS_MODE: mode_next = i_wdata[1:0];
            default: ;
         endcase
      end
      // the command result wins over a bus write to the data register
      if (state_reg == TSW_EXEC) begin
         if (cmd_reg == CMD_RD_DATA) begin
            data_next = cm_reg[cm_idx].ptr; // R1
         end else if (cmd_reg == CMD_RD_CODE) begin
            data_next = {4'h0, cm_reg[cm_idx].code}; // R2
         end else if (cmd_reg == CMD_WR_DATA) begin
            cm_we        = 1'b1;
            cm_wline.ptr = data_reg; // R16
         end else if (cmd_reg[7:4] == CMD_SW_HI && cmd_reg[3] == 1'b0) begin
            cm_we    = 1'b1;
            cm_wline = '{code: cmd_reg[3:0], ptr: data_reg}; // R3 R12 R15
         end else if (cmd_reg == CMD_WR_UP) begin
            cm_we    = 1'b1;
            cm_wline = '{code: CODE_UP, ptr: data_reg}; // R4
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= RESP_OKAY;
         data_reg   <= 8'h00;
         addr_reg   <= 8'h00;
         cmd_reg    <= 8'h00;
         mode_reg   <= MODE_4X32;
         state_reg  <= TSW_IDLE;
      end else begin
         bvalid_reg <= bvalid_next;
         bresp_reg  <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg  <= rdata_next;
         rresp_reg  <= rresp_next;
         data_reg   <= data_next;
         addr_reg   <= addr_next;
         cmd_reg    <= cmd_next;
         mode_reg   <= mode_next;
         state_reg  <= state_next;
      end
   end

   // control memory starts all unassigned
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int i = 0; i < 2*NUM_SLOTS; i++) begin
            cm_reg[i] <= '{code: CODE_NONE, ptr: 8'h00};
         end
      end else if (cm_we) begin
         cm_reg[cm_idx] <= cm_wline;
      end
   end

   assign o_bvalid = bvalid_reg;
   assign o_bresp  = bresp_reg;
   assign o_rvalid = rvalid_reg;
   assign o_rdata  = rdata_reg;
   assign o_rresp  = rresp_reg;

   // ---------------- switching engine ----------------
   logic [2:0]  bit_reg, bit_next;
   logic [6:0]  slot_reg, slot_next;
   logic [7:0]  pcm_rsh_reg, pcm_rsh_next, cfi_rsh_reg, cfi_rsh_next;
   logic [7:0]  pcm_tsh_reg, pcm_tsh_next, cfi_tsh_reg, cfi_tsh_next;
   logic [7:0]  oe_sh_reg, oe_sh_next;
   logic        slot_end;
   logic [7:0]  pcm_byte, cfi_byte, up_mask, dn_mask, dn_src;
   tsw_cm_line_t dn_line, up_line;
   logic [6:0]  up_ptr;

   // frame timing, each slot eight contiguous bits, bit 7 first
   always_comb begin
      slot_end  = (bit_reg == LAST_BIT); // R8
      bit_next  = bit_reg + 3'h1;
      slot_next = slot_end ? slot_reg + 7'h01 : slot_reg;
      bank_next = (slot_end && slot_reg == 7'(NUM_SLOTS - 1)) ? ~bank_reg : bank_reg;
      pcm_byte  = {pcm_rsh_reg[6:0], i_pcm_rx}; // R9
      cfi_byte  = {cfi_rsh_reg[6:0], i_cfi_rx};
      pcm_rsh_next = pcm_byte;
      cfi_rsh_next = cfi_byte;
      // next slot's outgoing bytes come from the bank filled last frame
      dn_line = cm_reg[{1'b0, slot_next}];
      up_line = cm_reg[{1'b1, slot_reg}];
      dn_mask = code_mask(dn_line.code);
      up_mask = code_mask(up_line.code);
      up_ptr  = up_line.ptr[6:0];
      dn_src  = dm_down[~bank_next][dn_line.ptr[6:0]]; // R5 R13
      pcm_tsh_next = {pcm_tsh_reg[6:0], 1'b0};
      cfi_tsh_next = {cfi_tsh_reg[6:0], 1'b0};
      oe_sh_next   = {oe_sh_reg[6:0], 1'b0};
      if (slot_end) begin
         pcm_tsh_next = dm_up[~bank_next][slot_next]; // R10
         if (dn_line.code == CODE_UP) begin
            cfi_tsh_next = dn_line.ptr;
            oe_sh_next   = 8'hff;
         end else begin
            cfi_tsh_next = dn_src & dn_mask;
            oe_sh_next   = dn_mask; // R19
         end
      end
   end

   // data memory writes at each slot end; upstream merges only the coded bits
   always_ff @(posedge i_ref_clk) begin
      if (slot_end) begin
         dm_down[bank_reg][slot_reg] <= pcm_byte;
         if (up_mask != 8'h00) begin
            dm_up[bank_reg][up_ptr] <= (dm_up[bank_reg][up_ptr] & ~up_mask)
                                       | (cfi_byte & up_mask); // R14
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         bit_reg     <= 3'h0;
         slot_reg    <= 7'h00;
         bank_reg    <= 1'b0;
         pcm_rsh_reg <= 8'h00;
         cfi_rsh_reg <= 8'h00;
         pcm_tsh_reg <= 8'h00;
         cfi_tsh_reg <= 8'h00;
         oe_sh_reg   <= 8'h00;
      end else begin
         bit_reg     <= bit_next;
         slot_reg    <= slot_next;
         bank_reg    <= bank_next;
         pcm_rsh_reg <= pcm_rsh_next;
         cfi_rsh_reg <= cfi_rsh_next;
         pcm_tsh_reg <= pcm_tsh_next;
         cfi_tsh_reg <= cfi_tsh_next;
         oe_sh_reg   <= oe_sh_next;
      end
   end

   // outputs shift msb first from flip-flops
   assign o_pcm_tx      = pcm_tsh_reg[7];
   assign o_cfi_tx      = cfi_tsh_reg[7];
   assign o_cfi_tx_oe   = oe_sh_reg[7];
   assign o_frame_start = (bit_reg == 3'h0) && (slot_reg == 7'h00);
endmodule

// ### tsw_props.sv
// bus and frame checks on the switch core ports
// assumes one clock domain with asynchronous active low reset
`timescale 1ns/100ps
module tsw_props (
   // clock and reset
   input wire logic        i_ref_clk,
   input wire logic        i_rstn,
   // register bus
   input wire logic        i_awvalid,
   input wire logic        o_awready,
   input wire logic        i_wvalid,
   input wire logic        o_bvalid,
   input wire logic        i_bready,
   input wire logic [1:0]  o_bresp,
   input wire logic        i_arvalid,
   input wire logic        o_arready,
   input wire logic        o_rvalid,
   input wire logic        i_rready,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0]  o_rresp,
   // frame marker
   input wire logic        o_frame_start
);
   logic [9:0] fcnt_reg;
   logic       seen_reg;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   sequence wr_take;
      i_awvalid && o_awready;
   endsequence
   sequence rd_take;
      i_arvalid && o_arready;
   endsequence
   // cycles since last frame marker, a frame is 128 slots of 8 bits
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         fcnt_reg <= 10'h000;
         seen_reg <= 1'b0;
      end else begin
         fcnt_reg <= o_frame_start ? 10'h001 : fcnt_reg + 10'h001;
         seen_reg <= seen_reg | o_frame_start;
      end
   end
   AST_AW_READY: assert property (o_awready == (i_awvalid && i_wvalid && !o_bvalid))
      else $error("write ready wrong");
   AST_AR_READY: assert property (o_arready == (i_arvalid && !o_rvalid))
      else $error("read ready wrong");
   AST_B_AFTER: assert property (wr_take |=> o_bvalid)
      else $error("write response late");
   AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped");
   AST_R_AFTER: assert property (rd_take |=> o_rvalid)
      else $error("read response late");
   AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped");
   AST_RDATA_HI: assert property (o_rvalid |-> o_rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   AST_RESP_OK: assert property (o_rvalid |-> o_rresp == 2'h0 || o_rresp == 2'h2)
      else $error("bad read response");
   AST_FRAME: assert property (o_frame_start && seen_reg |-> fcnt_reg == 10'h000)
      else $error("frame length wrong");
endmodule
bind tsw_core tsw_props tsw_props_inst (.*);

// ### tsw_line_model.sv
// far side of both serial highways, one byte pattern per slot
// assumes frame start marks slot 0 bit 7 in the same cycle
`timescale 1ns/100ps
module tsw_line_model (
   // clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_rstn,
   // frame marker from the core
   input  wire logic i_frame_start,
   // serial lines into the core
   output logic      o_pcm_bit,
   output logic      o_cfi_bit
);
   logic [9:0] cnt_reg;
   logic [9:0] pos;
   logic [7:0] pb;
   function automatic logic [7:0] pcm_byte(input logic [6:0] s);
      return {s, 1'b0} ^ 8'h5a;
   endfunction
   // position follows the marker so the model never drifts from the core
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) cnt_reg <= 10'h000;
      else cnt_reg <= i_frame_start ? 10'h001 : cnt_reg + 10'h001;
   end
   // bit 7 first, eight bits per slot
   assign pos = i_frame_start ? 10'h000 : cnt_reg;
   assign pb = pcm_byte(pos[9:3]);
   assign o_pcm_bit = pb[3'h7 - pos[2:0]];
   assign o_cfi_bit = ~pb[3'h7 - pos[2:0]];
endmodule

// ### timeslot_switch_memory_control_bench.sv
// self-checking bench: register programming and serial switching
// assumes the line model drives both receive highways
`timescale 1ns/100ps
module timeslot_switch_memory_control_bench;
   import tsw_pkg::*;
   `define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
   logic i_ref_clk = 1'b0, i_rstn = 1'b0;
   logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
   logic i_arvalid = 1'b0, i_rready = 1'b0;
   logic [4:0] i_awaddr = 5'h00, i_araddr = 5'h00;
   logic [31:0] i_wdata = 32'h0, o_rdata, rq;
   logic [3:0] i_wstrb = 4'hf;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0] o_bresp, o_rresp, bq;
   logic pcm_rx, cfi_rx, o_pcm_tx, o_cfi_tx, o_cfi_tx_oe, o_frame_start;
   logic [7:0] v, b, oe;
   int err_count = 0, checks = 0, cyc = 0;
   tsw_core tsw_core_inst (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
      .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
      .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
      .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
      .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
      .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
      .i_pcm_rx(pcm_rx), .o_pcm_tx(o_pcm_tx), .i_cfi_rx(cfi_rx), .o_cfi_tx(o_cfi_tx),
      .o_cfi_tx_oe(o_cfi_tx_oe), .o_frame_start(o_frame_start));
   tsw_line_model tsw_line_model_inst (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
      .i_frame_start(o_frame_start), .o_pcm_bit(pcm_rx), .o_cfi_bit(cfi_rx));
   always #5 i_ref_clk = ~i_ref_clk;
   // hang guard well above the expected run
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // write: address and data offered together, held until taken
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_awvalid <= 1'b1; i_wvalid <= 1'b1; i_awaddr <= a; i_wdata <= {24'h0, d};
      do @(negedge i_ref_clk); while (o_awready !== 1'b1);
      @(posedge i_ref_clk);
      i_awvalid <= 1'b0; i_wvalid <= 1'b0; i_bready <= 1'b1;
      do @(negedge i_ref_clk); while (o_bvalid !== 1'b1);
      bq = o_bresp;
      @(posedge i_ref_clk);
      i_bready <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a);
      @(posedge i_ref_clk);
      i_arvalid <= 1'b1; i_araddr <= a;
      do @(negedge i_ref_clk); while (o_arready !== 1'b1);
      @(posedge i_ref_clk);
      i_arvalid <= 1'b0; i_rready <= 1'b1;
      do @(negedge i_ref_clk); while (o_rvalid !== 1'b1);
      rq = o_rdata; bq = o_rresp;
      @(posedge i_ref_clk);
      i_rready <= 1'b0;
   endtask
   // operands first, the command write launches the operation
   task automatic prog(input logic [7:0] d, input logic [7:0] a, input logic [7:0] c);
      wr(OFS_DATA, d); wr(OFS_ADDR, a); wr(OFS_CMD, c);
   endtask
   task automatic rdback(input logic [7:0] a, input logic [7:0] c);
      wr(OFS_ADDR, a); wr(OFS_CMD, c);
      do rd(OFS_STATUS); while (rq[BUSY_BIT] !== 1'b0);
      rd(OFS_DATA);
      v = rq[7:0];
   endtask
   // grab slot s of the next frame, bit 7 first
   task automatic cap(input int s, input logic up);
      do @(negedge i_ref_clk); while (o_frame_start !== 1'b1);
      repeat (s * 8) @(negedge i_ref_clk);
      for (int i = 7; i >= 0; i--) begin
         b[i] = up ? o_pcm_tx : o_cfi_tx;
         oe[i] = o_cfi_tx_oe;
         if (i > 0) @(negedge i_ref_clk);
      end
   endtask
   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      wr(OFS_MODE, {6'h0, MODE_1X128}); rd(OFS_MODE); `CHK(rq, 32'h2)
      rd(OFS_STATUS); `CHK(rq[BUSY_BIT], 1'b0)
      wr(5'h14, 8'h11); `CHK(bq, RESP_SLVERR)
      rd(5'h14); `CHK(bq, RESP_SLVERR)
      // a write with lane 0 disabled is answered but changes nothing
      i_wstrb <= 4'h0;
      wr(OFS_DATA, 8'hff); `CHK(bq, RESP_OKAY)
      i_wstrb <= 4'hf;
      rd(OFS_DATA); `CHK(rq, 32'h0)
      cap(0, 1'b0); `CHK(oe, 8'h00)
      $display("test registers done");
      for (int k = 0; k < 8; k++) begin
         prog(8'h10 + 8'(k), 8'(k), 8'h70 + 8'(k));
         rdback(8'(k), CMD_RD_CODE); `CHK(v, 8'(k))
         rdback(8'(k), CMD_RD_DATA); `CHK(v, 8'h10 + 8'(k))
      end
      prog(8'h33, 8'h01, CMD_WR_DATA);
      rdback(8'h01, CMD_RD_CODE); `CHK(v, 8'h01)
      rdback(8'h01, CMD_RD_DATA); `CHK(v, 8'h33)
      prog(8'hc3, 8'h02, CMD_WR_UP);
      rdback(8'h02, CMD_RD_CODE); `CHK(v, 8'(CODE_UP))
      rdback(8'h02, CMD_RD_DATA); `CHK(v, 8'hc3)
      $display("test commands done");
      prog(8'h05, 8'h00, 8'h71); prog(8'h05, 8'h03, 8'h71);
      prog(8'h09, 8'h82, 8'h71); prog(8'h00, 8'h01, 8'h70);
      repeat (2100) @(posedge i_ref_clk);
      v = tsw_line_model_inst.pcm_byte(7'h05);
      cap(0, 1'b0); `CHK(b, v)
      `CHK(oe, 8'hff)
      cap(3, 1'b0); `CHK(b, v)
      cap(1, 1'b0); `CHK(oe, 8'h00)
      cap(9, 1'b1); `CHK(b, ~tsw_line_model_inst.pcm_byte(7'h02))
      // line 4 holds code 0100 from the loop: only bits 1..0 pass and drive
      cap(4, 1'b0); `CHK(b, tsw_line_model_inst.pcm_byte(7'h14) & 8'h03)
      `CHK(oe, 8'h03)
      $display("test switching done");
      // other port layouts map the same lines from other host addresses
      wr(OFS_MODE, {6'h0, MODE_8X16});
      rdback(8'h40, CMD_RD_CODE); `CHK(v, 8'h04)
      wr(OFS_MODE, {6'h0, MODE_4X32});
      rdback(8'h21, CMD_RD_CODE); `CHK(v, 8'h05)
      $display("test port layouts done");
      conclude();
   end
endmodule
